//--- rtl/llbc_pkg.sv
// package of constants and carriers for the legacy link byte channel
// Functional notes
// - receive link bits shift singly into byte
// - eight bits complete byte, set full flag
// - unmasked full flag pulls interrupt low
// - byte equal to either match sets flag
// - destuffer drops zero after exactly five ones
// - zero after six or more ones kept
// - earliest received bit lands in bit zero
// - transmit byte sent least significant first
// - eight bits sent sets empty flag, interrupt
// - unwritten transmit byte is resent unchanged
// - stuffer inserts zero after five ones
// - source select zero takes bits from byte
// - multiframe load waits for multiframe boundary
// - slc96 fields use the same byte registers
// - runs alongside separate hdlc controller, independently
package llbc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RX_LINK_BYTE    = 8'h28;
  localparam logic [7:0] IDX_RX_LINK_MATCH_A = 8'h29;
  localparam logic [7:0] IDX_RX_LINK_MATCH_B = 8'h2a;
  localparam logic [7:0] IDX_TX_LINK_BYTE    = 8'h7e;
  localparam logic [7:0] IDX_STATUS          = 8'h60;
  localparam logic [7:0] IDX_MASK            = 8'h61;
  localparam logic [7:0] IDX_CTRL            = 8'h62;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int ST_RX_FULL  = 0;
  localparam int ST_MATCH    = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int CT_DESTUFF  = 0;
  localparam int CT_STUFF    = 1;
  localparam int CT_FS_SRC   = 2;
  localparam int CT_MF_LOAD  = 3;
  localparam int CT_D4_MODE  = 4;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [2:0] RST_STATUS = 3'h0;
  localparam logic [2:0] RST_MASK   = 3'h0;
  localparam logic [4:0] RST_CTRL   = 5'h00;
  localparam logic [2:0] STUFF_RUN  = 3'h5;
  localparam logic [3:0] BYTE_LAST  = 4'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_valid;  // one recovered link bit present
    logic rx_bit;
    logic tx_req;    // framer wants the next outgoing link bit
    logic mf_start;  // multiframe boundary strobe
  } llbc_link_in_s;

  typedef struct packed {
    logic [7:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic [2:0]  rx_ones;
    logic [7:0]  rx_byte;
    logic [7:0]  match_a;
    logic [7:0]  match_b;
    logic [7:0]  tx_byte;
    logic [7:0]  tx_sh;
    logic [3:0]  tx_cnt;
    logic [2:0]  tx_ones;
    logic        tx_wait;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [4:0]  ctrl;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] rdata;
    logic        irq_n;
    logic        tx_bit;
    logic        tx_own;
  } llbc_state_s;

endpackage : llbc_pkg

//--- rtl/llbc_top.sv
// legacy link byte channel: ahb-lite registers, receive and transmit link byte paths
`timescale 1ns/1ps
module llbc_top (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // framer link side
  input  wire llbc_pkg::llbc_link_in_s link_in,
  output logic                        link_tx_bit,
  output logic                        link_tx_own,
  // interrupt
  output logic                        irq_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  llbc_pkg::llbc_state_s s_ff;
  llbc_pkg::llbc_state_s nxt_s;
  logic                  resp_ff;
  logic                  ready_ff;

  // register read decode, used only by the bus read path
  function automatic logic [31:0] reg_read(input llbc_pkg::llbc_state_s r,
                                           input logic [7:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      llbc_pkg::IDX_RX_LINK_BYTE:    v[7:0] = r.rx_byte;
      llbc_pkg::IDX_RX_LINK_MATCH_A: v[7:0] = r.match_a;
      llbc_pkg::IDX_RX_LINK_MATCH_B: v[7:0] = r.match_b;
      llbc_pkg::IDX_TX_LINK_BYTE:    v[7:0] = r.tx_byte;
      llbc_pkg::IDX_STATUS:          v[2:0] = r.status;
      llbc_pkg::IDX_MASK:            v[2:0] = r.mask;
      llbc_pkg::IDX_CTRL:            v[4:0] = r.ctrl;
      default:                       v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_read

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one process for bus writes, link paths, flags and read data
  always_comb begin
    llbc_pkg::llbc_state_s n;
    logic [2:0] ev;
    logic [2:0] clr;
    logic       drop;
    logic [7:0] rx_full_byte;
    n            = s_ff;
    ev           = 3'h0;
    clr          = 3'h0;
    drop         = 1'b0;
    rx_full_byte = {link_in.rx_bit, s_ff.rx_sh[7:1]};

    // data phase of a write lands here; unmapped indices are ignored
    if (s_ff.wr_pend) begin
      unique case (s_ff.wr_idx)
        llbc_pkg::IDX_RX_LINK_MATCH_A: n.match_a = hwdata[7:0];
        llbc_pkg::IDX_RX_LINK_MATCH_B: n.match_b = hwdata[7:0];
        llbc_pkg::IDX_TX_LINK_BYTE:    n.tx_byte = hwdata[7:0];
        llbc_pkg::IDX_STATUS:          clr = hwdata[2:0];
        llbc_pkg::IDX_MASK:            n.mask = hwdata[2:0];
        llbc_pkg::IDX_CTRL:            n.ctrl = hwdata[4:0];
        default:                       clr = 3'h0;
      endcase
    end

    // receive path: destuff then shift in lsb first
    if (link_in.rx_valid) begin
      drop = s_ff.ctrl[llbc_pkg::CT_DESTUFF] && !link_in.rx_bit &&
             (s_ff.rx_ones == llbc_pkg::STUFF_RUN);
      if (link_in.rx_bit) begin
        if (s_ff.rx_ones != 3'h7) n.rx_ones = s_ff.rx_ones + 3'h1;
      end else begin
        n.rx_ones = 3'h0;
      end
      if (!drop) begin
        n.rx_sh = rx_full_byte;
        if (s_ff.rx_cnt == llbc_pkg::BYTE_LAST) begin
          n.rx_cnt  = 4'h0;
          n.rx_byte = rx_full_byte;
          ev[llbc_pkg::ST_RX_FULL] = 1'b1;
          if (rx_full_byte == n.match_a || rx_full_byte == n.match_b)
            ev[llbc_pkg::ST_MATCH] = 1'b1;
        end else begin
          n.rx_cnt = s_ff.rx_cnt + 4'h1;
        end
      end
    end

    // transmit reload on a multiframe boundary when loading is deferred
    if (s_ff.tx_wait && link_in.mf_start) begin
      n.tx_wait = 1'b0;
      n.tx_sh   = n.tx_byte;
      n.tx_cnt  = 4'h0;
    end

    // transmit path: one bit per framer request, stuffing first
    if (link_in.tx_req) begin
      if (s_ff.tx_wait) begin
        n.tx_bit = 1'b1;  // idle ones while waiting for the boundary
      end else if (s_ff.ctrl[llbc_pkg::CT_STUFF] &&
                   s_ff.tx_ones == llbc_pkg::STUFF_RUN) begin
        n.tx_bit  = 1'b0;
        n.tx_ones = 3'h0;
      end else begin
        n.tx_bit = s_ff.tx_sh[0];
        n.tx_sh  = {1'b0, s_ff.tx_sh[7:1]};
        if (s_ff.tx_sh[0]) begin
          if (s_ff.tx_ones != 3'h7) n.tx_ones = s_ff.tx_ones + 3'h1;
        end else begin
          n.tx_ones = 3'h0;
        end
        if (s_ff.tx_cnt == llbc_pkg::BYTE_LAST) begin
          ev[llbc_pkg::ST_TX_EMPTY] = 1'b1;
          n.tx_cnt = 4'h0;
          // the held byte goes again if software has not rewritten it
          if (s_ff.ctrl[llbc_pkg::CT_MF_LOAD]) begin
            n.tx_wait = 1'b1;
          end else begin
            n.tx_sh = n.tx_byte;
          end
        end else begin
          n.tx_cnt = s_ff.tx_cnt + 4'h1;
        end
      end
    end

    // this block sources the bits only while the select bit is zero
    n.tx_own = !n.ctrl[llbc_pkg::CT_FS_SRC];

    // sticky flags: a new event wins over a write-one clear
    n.status = (s_ff.status & ~clr) | ev;
    n.irq_n  = !(|(n.status & n.mask));

    // address phase: capture writes, precompute reads from updated values
    n.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      n.wr_pend = hwrite;
      n.wr_idx  = haddr[9:2];
      if (!hwrite) n.rdata = reg_read(n, haddr[9:2]);
    end
    nxt_s = n;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // single state register; reset takes constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff         <= '0;
      s_ff.rx_byte <= llbc_pkg::RST_BYTE;
      s_ff.match_a <= llbc_pkg::RST_BYTE;
      s_ff.match_b <= llbc_pkg::RST_BYTE;
      s_ff.tx_byte <= llbc_pkg::RST_BYTE;
      s_ff.status  <= llbc_pkg::RST_STATUS;
      s_ff.mask    <= llbc_pkg::RST_MASK;
      s_ff.ctrl    <= llbc_pkg::RST_CTRL;
      s_ff.irq_n   <= 1'b1;
      s_ff.tx_bit  <= 1'b1;
      s_ff.tx_own  <= 1'b1;
      resp_ff      <= 1'b0;
      ready_ff     <= 1'b1;
    end else begin
      s_ff     <= nxt_s;
      resp_ff  <= 1'b0;
      ready_ff <= 1'b1;
    end
  end

  // outputs straight from flops; slave never stretches a transfer
  assign hrdata      = s_ff.rdata;
  assign hreadyout   = ready_ff;
  assign hresp       = resp_ff;
  assign link_tx_bit = s_ff.tx_bit;
  assign link_tx_own = s_ff.tx_own;
  assign irq_n       = s_ff.irq_n;

  // ----------------------------------------------------------------
  // behaviour notes
  // ----------------------------------------------------------------
  // bus side:
  //   every transfer is taken in one address phase and answered in
  //   the very next cycle; the slave never inserts a wait state
  //   read data is worked out from the next-state copy, so a read
  //   right behind a write to the same register sees the new value
  //   hrdata holds until the next read address phase is taken
  //   unmapped indices read zero and swallow writes silently
  // receive side:
  //   one recovered bit per rx_valid pulse, shifted in from the top
  //   so that the earliest bit ends up in bit zero of the byte
  //   a completed byte simply overwrites the last one: software that
  //   falls behind loses bytes, there is no overrun indication
  //   the ones counter saturates at seven, so long runs of ones
  //   never wrap back to exactly five and cause a false drop
  //   the match compares against match values after any same-cycle
  //   write, so a freshly written pattern takes effect at once
  // transmit side:
  //   one outgoing bit per tx_req pulse, shown on link_tx_bit in
  //   the following cycle and held until the next request
  //   a stuffed zero does not consume a data bit, so a byte with
  //   five ones in a row takes nine requests instead of eight
  //   after reset the shifter holds zero, so the first byte on the
  //   line is all zeros before the written byte is picked up
  //   with multiframe loading, requests between the end of a byte
  //   and the next boundary are answered with idle ones
  // flags:
  //   a new event wins over a same-cycle write-one clear, trading a
  //   possible extra interrupt for never losing an event
  //   the interrupt is registered from the next flags, so it changes in the same cycle as the flags

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_rx_byte_done: assert property (
    link_in.rx_valid && s_ff.rx_cnt == llbc_pkg::BYTE_LAST &&
    !(s_ff.ctrl[0] && !link_in.rx_bit && s_ff.rx_ones == 3'h5)
    |=> s_ff.status[0] && s_ff.rx_cnt == 4'h0)
    else $error("receive byte completion did not set full flag");

  a_rx_lsb_first: assert property (
    link_in.rx_valid && s_ff.rx_cnt == llbc_pkg::BYTE_LAST &&
    !(s_ff.ctrl[0] && !link_in.rx_bit && s_ff.rx_ones == 3'h5)
    |=> s_ff.rx_byte[7] == $past(link_in.rx_bit) &&
        s_ff.rx_byte[0] == $past(s_ff.rx_sh[1]))
    else $error("receive byte bit order wrong");

  a_destuff_drop: assert property (
    link_in.rx_valid && s_ff.ctrl[0] && !link_in.rx_bit && s_ff.rx_ones == 3'h5
    |=> $stable(s_ff.rx_cnt) && $stable(s_ff.rx_sh))
    else $error("stuffed zero was not removed");

  a_destuff_keep: assert property (
    link_in.rx_valid && !link_in.rx_bit && s_ff.rx_ones > 3'h5
    |=> s_ff.rx_sh[7] == 1'b0 && !$stable(s_ff.rx_cnt))
    else $error("zero after long run of ones was dropped");

  a_match_flag: assert property (
    s_ff.status[0] && !$past(s_ff.status[0]) &&
    (s_ff.rx_byte == s_ff.match_a) && !$past(s_ff.wr_pend)
    |-> s_ff.status[1])
    else $error("match flag not set on equal byte");

  a_irq_level: assert property (
    s_ff.irq_n == !(|(s_ff.status & s_ff.mask)))
    else $error("interrupt level disagrees with flags and mask");

  a_tx_lsb_out: assert property (
    link_in.tx_req && !s_ff.tx_wait && !(s_ff.ctrl[1] && s_ff.tx_ones == 3'h5)
    |=> s_ff.tx_bit == $past(s_ff.tx_sh[0]))
    else $error("transmit bit is not the shifter lsb");

  a_stuff_zero: assert property (
    link_in.tx_req && !s_ff.tx_wait && s_ff.ctrl[1] && s_ff.tx_ones == 3'h5
    |=> !s_ff.tx_bit ##0 $stable(s_ff.tx_cnt))
    else $error("no stuffed zero after five ones");

  a_tx_empty: assert property (
    link_in.tx_req && !s_ff.tx_wait && s_ff.tx_cnt == llbc_pkg::BYTE_LAST &&
    !(s_ff.ctrl[1] && s_ff.tx_ones == 3'h5)
    |=> s_ff.status[2] && (s_ff.tx_wait || s_ff.tx_sh == $past(nxt_s.tx_byte)))
    else $error("byte end did not flag empty or reload");

  a_mf_hold: assert property (
    s_ff.tx_wait && !link_in.mf_start |=> s_ff.tx_wait)
    else $error("deferred load left wait without boundary");

  a_flag_sticky: assert property (
    s_ff.status[0] && !(s_ff.wr_pend && s_ff.wr_idx == llbc_pkg::IDX_STATUS)
    |=> s_ff.status[0])
    else $error("status flag dropped without a clear");

  a_fs_source: assert property (
    ##1 s_ff.tx_own == !$past(nxt_s.ctrl[2]))
    else $error("bit source indication wrong");

  c_rx_match:   cover property (s_ff.status[1] && !s_ff.irq_n);
  c_destuff:    cover property (link_in.rx_valid && s_ff.ctrl[0] &&
                                !link_in.rx_bit && s_ff.rx_ones == 3'h5);
  c_tx_stuff:   cover property (link_in.tx_req && s_ff.ctrl[1] &&
                                s_ff.tx_ones == 3'h5 && !s_ff.tx_wait);
  c_mf_reload:  cover property (s_ff.tx_wait && link_in.mf_start);
  c_tx_empty:   cover property (s_ff.status[2] && !s_ff.irq_n);

  // the bus never stretches a transfer
  a_bus_ready: assert property (
    hreadyout)
    else $error("slave inserted a wait state");

  // every response is okay
  a_bus_okay: assert property (
    !hresp)
    else $error("slave answered with an error response");

  // without a received bit the shifter holds
  a_rx_idle_hold: assert property (
    !link_in.rx_valid |=> $stable(s_ff.rx_sh) && $stable(s_ff.rx_cnt))
    else $error("receive shifter moved without a bit");

  // a kept bit enters at the top of the shifter
  a_rx_shift_in: assert property (
    link_in.rx_valid &&
    !(s_ff.ctrl[0] && !link_in.rx_bit && s_ff.rx_ones == 3'h5)
    |=> s_ff.rx_sh[7] == $past(link_in.rx_bit))
    else $error("received bit not shifted in");

  // any received zero clears the ones run
  a_rx_ones_clr: assert property (
    link_in.rx_valid && !link_in.rx_bit |=> s_ff.rx_ones == 3'h0)
    else $error("ones run survived a zero");

  // the byte register changes only on completion
  a_rx_byte_hold: assert property (
    !(link_in.rx_valid && s_ff.rx_cnt == llbc_pkg::BYTE_LAST)
    |=> $stable(s_ff.rx_byte))
    else $error("receive byte changed between completions");

  // the full flag rises only with a completed byte
  a_full_cause: assert property (
    !(link_in.rx_valid && s_ff.rx_cnt == llbc_pkg::BYTE_LAST) &&
    !s_ff.status[0] |=> !s_ff.status[0])
    else $error("full flag set without a byte");

  // match and empty flags are sticky as well
  a_match_sticky: assert property (
    s_ff.status[1] && !(s_ff.wr_pend && s_ff.wr_idx == llbc_pkg::IDX_STATUS)
    |=> s_ff.status[1])
    else $error("match flag dropped without a clear");

  a_empty_sticky: assert property (
    s_ff.status[2] && !(s_ff.wr_pend && s_ff.wr_idx == llbc_pkg::IDX_STATUS)
    |=> s_ff.status[2])
    else $error("empty flag dropped without a clear");

  // the outgoing bit holds between requests
  a_tx_idle_hold: assert property (
    !link_in.tx_req |=> $stable(s_ff.tx_bit))
    else $error("outgoing bit changed without a request");

  // byte end without deferred loading reloads the held byte
  a_tx_resend: assert property (
    link_in.tx_req && !s_ff.tx_wait && s_ff.tx_cnt == llbc_pkg::BYTE_LAST &&
    !(s_ff.ctrl[1] && s_ff.tx_ones == 3'h5) && !s_ff.ctrl[3]
    |=> !s_ff.tx_wait && s_ff.tx_sh == $past(nxt_s.tx_byte))
    else $error("held byte not reloaded at byte end");

  // byte end with deferred loading waits for the boundary
  a_mf_enter: assert property (
    link_in.tx_req && !s_ff.tx_wait && s_ff.tx_cnt == llbc_pkg::BYTE_LAST &&
    !(s_ff.ctrl[1] && s_ff.tx_ones == 3'h5) && s_ff.ctrl[3]
    |=> s_ff.tx_wait)
    else $error("deferred load did not wait for boundary");

  // requests while waiting are answered with idle ones
  a_wait_idle: assert property (
    link_in.tx_req && s_ff.tx_wait |=> s_ff.tx_bit)
    else $error("waiting transmitter sent a zero");

  // the boundary loads the byte and restarts the count
  a_mf_reload: assert property (
    s_ff.tx_wait && link_in.mf_start
    |=> !s_ff.tx_wait && s_ff.tx_cnt == 4'h0 &&
        s_ff.tx_sh == $past(nxt_s.tx_byte))
    else $error("boundary did not load the transmit byte");

endmodule : llbc_top

//--- tb/llbc_far_model.sv
// far-end framer model: feeds recovered link bits, pulls outgoing bits
`timescale 1ns/1ps
module llbc_far_model (
  // clock
  input  wire logic               hclk,
  // link side of the block
  output llbc_pkg::llbc_link_in_s link_in,
  input  wire logic               link_tx_bit
);
  // ----------------------------------------------------------------
  // framer strobes, each task starts just after a rising edge
  // ----------------------------------------------------------------
  initial begin
    link_in = '0;
  end

  // recovered bits lsb first; an unqualified data line shows the inverse
  task automatic send_bits(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      link_in.rx_valid <= 1'b1;
      link_in.rx_bit   <= v[i];
      @(posedge hclk);
      link_in.rx_valid <= 1'b0;
      link_in.rx_bit   <= ~v[i];
    end
  endtask : send_bits

  // one request per bit, bit read once the taking edge has landed
  task automatic take_bits(input int n, output logic [15:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      link_in.tx_req <= 1'b1;
      @(posedge hclk);
      link_in.tx_req <= 1'b0;
      #1;
      v[i] = link_tx_bit;
    end
  endtask : take_bits

  // single multiframe boundary strobe
  task automatic boundary();
    @(posedge hclk);
    link_in.mf_start <= 1'b1;
    @(posedge hclk);
    link_in.mf_start <= 1'b0;
  endtask : boundary
endmodule : llbc_far_model

//--- tb/llbc_top_test.sv
// self-checking bench for the legacy link byte channel
`timescale 1ns/1ps
module llbc_top_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                    hclk;
  logic                    hresetn;
  logic                    hsel;
  logic [31:0]             haddr;
  logic [1:0]              htrans;
  logic                    hwrite;
  logic [31:0]             hwdata;
  logic [31:0]             hrdata;
  logic                    hreadyout;
  logic                    hresp;
  llbc_pkg::llbc_link_in_s link_in;
  logic                    link_tx_bit;
  logic                    link_tx_own;
  logic                    irq_n;
  int                      failures;
  int                      n_compared;
  logic [31:0]             rd;
  logic [15:0]             bits;
  logic [7:0]              v;
  logic [7:0]              ids [8] = '{8'h28, 8'h29, 8'h2a, 8'h7e, 8'h60, 8'h61, 8'h62, 8'h10};

  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;

  llbc_top llbc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_in(link_in),
    .link_tx_bit(link_tx_bit), .link_tx_own(link_tx_own), .irq_n(irq_n));

  llbc_far_model llbc_far_model_inst (.hclk(hclk), .link_in(link_in),
    .link_tx_bit(link_tx_bit));

  // ----------------------------------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // single word transfer; waits on hready in both phases
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready_ok() !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready_ok() !== 1'b1);
    rd = hrdata;
  endtask : xfer

  function automatic logic hready_ok();
    return hreadyout;
  endfunction : hready_ok

  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rc

  // registered outputs settle a cycle after the cause
  task automatic late(input logic got_sel, input logic exp);
    repeat (2) @(posedge hclk);
    #1;
    chk({31'h0, got_sel ? link_tx_own : irq_n}, {31'h0, exp});
  endtask : late

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset

  // expected line bits of one byte with ones-run stuffing
  function automatic logic [15:0] exp_stuff(input logic [7:0] b);
    logic [15:0] o;
    int          k;
    int          run;
    o = '0;
    k = 0;
    run = 0;
    for (int i = 0; i < 8; i++) begin
      o[k] = b[i];
      k++;
      run = b[i] ? run + 1 : 0;
      if (run == 5) begin
        k++;
        run = 0;
      end
    end
    return o;
  endfunction : exp_stuff

  task automatic tally_and_finish();
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    #(25 * 50000);
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    failures = 0;
    n_compared = 0;
    void'($urandom(62238));
    do_reset();
    foreach (ids[i]) rc(ids[i], 32'h0);
    v = 8'($urandom());
    xfer(1'b1, llbc_pkg::IDX_RX_LINK_MATCH_A, {24'h0, ~v});
    xfer(1'b1, llbc_pkg::IDX_RX_LINK_MATCH_B, {24'h0, v});
    rc(llbc_pkg::IDX_RX_LINK_MATCH_A, {24'h0, ~v});
    xfer(1'b1, llbc_pkg::IDX_RX_LINK_BYTE, 32'hff);
    rc(llbc_pkg::IDX_RX_LINK_BYTE, 32'h0);
    xfer(1'b1, llbc_pkg::IDX_MASK, 32'h3);
    llbc_far_model_inst.send_bits({8'h0, v}, 8);
    rc(llbc_pkg::IDX_RX_LINK_BYTE, {24'h0, v});
    rc(llbc_pkg::IDX_STATUS, 32'h3);
    late(1'b0, 1'b0);
    xfer(1'b1, llbc_pkg::IDX_STATUS, 32'h1);
    rc(llbc_pkg::IDX_STATUS, 32'h2);
    xfer(1'b1, llbc_pkg::IDX_STATUS, 32'h2);
    late(1'b0, 1'b1);
    llbc_far_model_inst.send_bits({8'h0, v ^ 8'h5a}, 8);
    rc(llbc_pkg::IDX_RX_LINK_BYTE, {24'h0, v ^ 8'h5a});
    do_reset();
    xfer(1'b1, llbc_pkg::IDX_CTRL, 32'h1);
    llbc_far_model_inst.send_bits(16'h01df, 9);
    rc(llbc_pkg::IDX_RX_LINK_BYTE, 32'hff);
    llbc_far_model_inst.send_bits(16'h0007, 8);
    rc(llbc_pkg::IDX_RX_LINK_BYTE, 32'h07);
    do_reset();
    xfer(1'b1, llbc_pkg::IDX_MASK, 32'h4);
    xfer(1'b1, llbc_pkg::IDX_TX_LINK_BYTE, {24'h0, v});
    llbc_far_model_inst.take_bits(8, bits);
    late(1'b0, 1'b0);
    rc(llbc_pkg::IDX_STATUS, 32'h4);
    for (int r = 0; r < 2; r++) begin
      llbc_far_model_inst.take_bits(8, bits);
      chk({16'h0, bits}, {24'h0, v});
    end
    late(1'b1, 1'b1);
    do_reset();
    xfer(1'b1, llbc_pkg::IDX_CTRL, 32'h2);
    xfer(1'b1, llbc_pkg::IDX_TX_LINK_BYTE, 32'hff);
    llbc_far_model_inst.take_bits(8, bits);
    llbc_far_model_inst.take_bits(9, bits);
    chk({16'h0, bits}, {16'h0, exp_stuff(8'hff)});
    do_reset();
    xfer(1'b1, llbc_pkg::IDX_CTRL, 32'h18);
    xfer(1'b1, llbc_pkg::IDX_TX_LINK_BYTE, 32'h1c);
    llbc_far_model_inst.take_bits(8, bits);
    llbc_far_model_inst.take_bits(2, bits);
    chk({16'h0, bits}, 32'h3);
    llbc_far_model_inst.boundary();
    llbc_far_model_inst.take_bits(8, bits);
    chk({16'h0, bits}, 32'h1c);
    xfer(1'b1, llbc_pkg::IDX_CTRL, 32'h1c);
    late(1'b1, 1'b0);
    tally_and_finish();
  end
endmodule : llbc_top_test
